// >>> shared/tdm_pkg.sv
package tdm_pkg;

    // Register indices; not every printed offset is a multiple of
    // four, so each printed offset is an index and the address is 4x it
    localparam logic [8:0]  IDX_GAIN_A   = 9'h07a;
    localparam logic [8:0]  IDX_GAIN_B   = 9'h07b;
    localparam logic [8:0]  IDX_REF      = 9'h07c;
    localparam logic [8:0]  IDX_TERM_A   = 9'h07e;
    localparam logic [8:0]  IDX_TERM_B   = 9'h07f;
    localparam logic [8:0]  IDX_DITHER   = 9'h09d;
    localparam logic [8:0]  IDX_MARKER   = 9'h160;
    localparam logic [8:0]  IDX_FUSE_ST  = 9'h161;
    localparam int          ADDR_W       = 11;
    localparam int          IDX_LSB      = 2;

    // Reset values
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam logic [7:0]  RST_DITHER   = 8'h01;

    // Field positions
    localparam int          REF_MSB      = 3;
    localparam int          DITH_EN_BIT  = 0;
    localparam int          DITH_AMP_BIT = 1;
    localparam int          DITH_ERR_BIT = 2;
    localparam int          MARK_EN_BIT  = 0;

    // Lane alignment parameter: control bits per sample
    localparam logic [1:0]  ILA_CS_VALUE = 2'h0;

    // Sample formats
    localparam int          SAMPLE_W     = 12;
    localparam int          NARROW_W     = 8;

    // Fuse load sequencer states (Gray coded)
    typedef enum logic [1:0] {
        FL_IDLE = 2'b00,
        FL_LOAD = 2'b01,
        FL_DONE = 2'b11
    } tdm_fuse_state_type;

endpackage

// >>> rtl/tdm_delay_line.sv
`timescale 1ns/1ps
// Fixed-length shift register; length is the sample path latency less the two sync flops
module tdm_delay_line #(
    parameter int DEPTH = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    logic [DEPTH-1:0] pipe_reg;

    // Marker travels one stage per pclk cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_reg <= '0;
        end else begin
            pipe_reg <= {pipe_reg[DEPTH-2:0], din};
        end
    end

    assign dout = pipe_reg[DEPTH-1];
endmodule

// >>> rtl/tdm_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Input A gain adjust, fuse-loaded, read/write
// - Input B gain adjust, fuse-loaded, read/write
// - Reference adjust 4 bits, upper bits zero
// - Input A termination adjust, fuse-loaded, writable
// - Input B termination adjust, fuse-loaded, writable
// - Dither enable bit 0, resets to one
// - Bit 1 selects small/large dither amplitude
// - Bit 2 selects rounding error destination
// - Marker enable puts timestamp on sample LSB
// - Timestamp delayed to match sample latency
// - Marker replaces LSB in 8/12-bit modes
// - Lane alignment reports zero control bits
module tdm_regs
    import tdm_pkg::*;
#(
    parameter int LATENCY = 4
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [tdm_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          fuse_valid,
    input  wire logic [7:0]                    fuse_gain_a,
    input  wire logic [7:0]                    fuse_gain_b,
    input  wire logic [3:0]                    fuse_ref,
    input  wire logic [7:0]                    fuse_term_a,
    input  wire logic [7:0]                    fuse_term_b,
    input  wire logic [7:0]                    fuse_dither,
    input  wire logic                          timestamp_in,
    input  wire logic                          narrow_mode,
    input  wire logic [tdm_pkg::SAMPLE_W-1:0]  sample_in,
    output logic      [tdm_pkg::SAMPLE_W-1:0]  sample_out,
    output logic      [7:0]                    gain_a_trim,
    output logic      [7:0]                    gain_b_trim,
    output logic      [3:0]                    reference_trim,
    output logic      [7:0]                    term_a_trim,
    output logic      [7:0]                    term_b_trim,
    output logic                               dither_enable,
    output logic                               dither_amplitude_select,
    output logic                               dither_rounding_select,
    output logic                               marker_enable,
    output logic      [1:0]                    ila_control_bits
);
    import tdm_pkg::*;

    logic [7:0]          gain_a_reg;
    logic [7:0]          gain_b_reg;
    logic [3:0]          ref_reg;
    logic [7:0]          term_a_reg;
    logic [7:0]          term_b_reg;
    logic [7:0]          dither_reg;
    logic                marker_reg;
    tdm_fuse_state_type  fl_state_reg;
    tdm_fuse_state_type  fl_state_next;
    logic [1:0]          fuse_sync_reg;
    logic                fuse_ok;
    logic                ts_meta_reg;
    logic                ts_sync_reg;
    logic                ts_delayed;
    logic [SAMPLE_W-1:0] sample_next;
    logic [SAMPLE_W-1:0] s_pipe_reg [LATENCY];

    // Decode; byte address is four times the register index
    wire [8:0] idx        = paddr[ADDR_W-1:IDX_LSB];
    wire       wr_en      = psel & penable & pwrite;
    wire       rd_en      = psel & penable & ~pwrite;
    wire       hit_gain_a = (idx == IDX_GAIN_A);
    wire       hit_gain_b = (idx == IDX_GAIN_B);
    wire       hit_ref    = (idx == IDX_REF);
    wire       hit_term_a = (idx == IDX_TERM_A);
    wire       hit_term_b = (idx == IDX_TERM_B);
    wire       hit_dither = (idx == IDX_DITHER);
    wire       hit_marker = (idx == IDX_MARKER);
    wire       hit_fuse   = (idx == IDX_FUSE_ST);
    wire       misaligned = |paddr[IDX_LSB-1:0];
    wire       mapped     = ~misaligned & (hit_gain_a | hit_gain_b |
                            hit_ref | hit_term_a | hit_term_b |
                            hit_dither | hit_marker | hit_fuse);
    wire       fuse_load  = (fl_state_reg == FL_LOAD);
    wire       sw_wr      = wr_en & mapped;

    // Read mux; reserved bits read as zero
    wire [7:0] rd_byte =
        hit_gain_a ? gain_a_reg :
        hit_gain_b ? gain_b_reg :
        hit_ref    ? {4'h0, ref_reg} :
        hit_term_a ? term_a_reg :
        hit_term_b ? term_b_reg :
        hit_dither ? {5'h00, dither_reg[DITH_ERR_BIT:DITH_EN_BIT]} :
        hit_marker ? {7'h00, marker_reg} :
        hit_fuse   ? {7'h00, (fl_state_reg == FL_DONE)} :
        RST_ZERO;

    // Fuse-valid strobe is from the fuse macro's timing, so synchronise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_sync_reg <= 2'h0;
        end else begin
            fuse_sync_reg <= {fuse_sync_reg[0], fuse_valid};
        end
    end
    assign fuse_ok = fuse_sync_reg[1];

    // Fuse loader: one load after reset, then software owns the values
    always_comb begin
        case (fl_state_reg)
            FL_IDLE: fl_state_next = fuse_ok ? FL_LOAD : FL_IDLE;
            FL_LOAD: fl_state_next = FL_DONE;
            FL_DONE: fl_state_next = FL_DONE;
            default: fl_state_next = FL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_state_reg <= FL_IDLE;
        end else begin
            fl_state_reg <= fl_state_next;
        end
    end

    // Trim registers; fuse load beats a coincident software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_a_reg <= RST_ZERO;
            gain_b_reg <= RST_ZERO;
            ref_reg    <= RST_ZERO[REF_MSB:0];
            term_a_reg <= RST_ZERO;
            term_b_reg <= RST_ZERO;
            dither_reg <= RST_DITHER;
        end else if (fuse_load) begin
            gain_a_reg <= fuse_gain_a;
            gain_b_reg <= fuse_gain_b;
            ref_reg    <= fuse_ref;
            term_a_reg <= fuse_term_a;
            term_b_reg <= fuse_term_b;
            dither_reg <= fuse_dither;
        end else if (sw_wr) begin
            if (hit_gain_a) gain_a_reg <= pwdata[7:0];
            if (hit_gain_b) gain_b_reg <= pwdata[7:0];
            if (hit_ref)    ref_reg <= pwdata[REF_MSB:0];
            if (hit_term_a) term_a_reg <= pwdata[7:0];
            if (hit_term_b) term_b_reg <= pwdata[7:0];
            if (hit_dither) dither_reg <= pwdata[7:0];
        end
    end

    // Marker enable is not fuse-loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            marker_reg <= 1'b0;
        end else if (sw_wr && hit_marker) begin
            marker_reg <= pwdata[MARK_EN_BIT];
        end
    end

    // APB answers in the access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite & mapped) ?
                       {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Timestamp pin is asynchronous; two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_meta_reg <= 1'b0;
            ts_sync_reg <= 1'b0;
        end else begin
            ts_meta_reg <= timestamp_in;
            ts_sync_reg <= ts_meta_reg;
        end
    end

    // Marker delay less the two sync flops, so it meets its own sample
    tdm_delay_line #(
        .DEPTH (LATENCY - 2)
    ) u_delay (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ts_sync_reg),
        .dout    (ts_delayed)
    );

    // LSB replacement; in narrow mode the 8-bit sample sits high-aligned
    always_comb begin
        sample_next = s_pipe_reg[LATENCY-1];
        if (marker_reg) begin
            if (narrow_mode) begin
                sample_next[SAMPLE_W-NARROW_W] = ts_delayed;
            end else begin
                sample_next[0] = ts_delayed;
            end
        end
    end

    // Sample path needs LATENCY cycles to match the delayed marker
    genvar g;
    generate
        for (g = 0; g < LATENCY; g++) begin : g_spipe
            if (g == 0) begin : g_head
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        s_pipe_reg[g] <= '0;
                    end else begin
                        s_pipe_reg[g] <= sample_in;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        s_pipe_reg[g] <= '0;
                    end else begin
                        s_pipe_reg[g] <= s_pipe_reg[g-1];
                    end
                end
            end
        end
    endgenerate

    // Output registers; control outputs follow registers one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_out              <= '0;
            gain_a_trim             <= RST_ZERO;
            gain_b_trim             <= RST_ZERO;
            reference_trim          <= RST_ZERO[REF_MSB:0];
            term_a_trim             <= RST_ZERO;
            term_b_trim             <= RST_ZERO;
            dither_enable           <= RST_DITHER[DITH_EN_BIT];
            dither_amplitude_select <= RST_DITHER[DITH_AMP_BIT];
            dither_rounding_select  <= RST_DITHER[DITH_ERR_BIT];
            marker_enable           <= 1'b0;
            ila_control_bits        <= ILA_CS_VALUE;
        end else begin
            sample_out              <= sample_next;
            gain_a_trim             <= gain_a_reg;
            gain_b_trim             <= gain_b_reg;
            reference_trim          <= ref_reg;
            term_a_trim             <= term_a_reg;
            term_b_trim             <= term_b_reg;
            dither_enable           <= dither_reg[DITH_EN_BIT];
            dither_amplitude_select <= dither_reg[DITH_AMP_BIT];
            dither_rounding_select  <= dither_reg[DITH_ERR_BIT];
            marker_enable           <= marker_reg;
            ila_control_bits        <= ILA_CS_VALUE;
        end
    end
endmodule

// >>> tb/tdm_regs_props.sv
`timescale 1ns/1ps
module tdm_regs_props
    import tdm_pkg::*;
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [tdm_pkg::ADDR_W-1:0]   paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         timestamp_in,
    input wire logic                         narrow_mode,
    input wire logic [tdm_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic [tdm_pkg::SAMPLE_W-1:0] sample_out,
    input wire logic [7:0]                   gain_a_trim,
    input wire logic [3:0]                   reference_trim,
    input wire logic                         dither_enable,
    input wire logic                         dither_amplitude_select,
    input wire logic                         dither_rounding_select,
    input wire logic                         marker_enable,
    input wire logic [1:0]                   ila_control_bits
);
    // Completed write; marker stable over two samples of one mode
    wire wr_done = psel && penable && pready && pwrite;
    logic [2:0] since_rst;
    // Cycles since reset; sample checks wait for the pipe to refill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rst <= 3'h0;
        end else if (since_rst != 3'h7) begin
            since_rst <= since_rst + 3'h1;
        end
    end
    wire pipe_full = (since_rst > 3'h5);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_setup_answer: assert property (psel && !penable |=> pready)
        else $error("setup cycle not answered");
    chk_gain_follow: assert property (wr_done && paddr == {IDX_GAIN_A, 2'b00}
        |-> ##2 gain_a_trim == $past(pwdata[7:0], 2)) else $error("gain trim");
    chk_ref_follow: assert property (wr_done && paddr == {IDX_REF, 2'b00}
        |-> ##2 reference_trim == $past(pwdata[3:0], 2)) else $error("ref trim");
    chk_dither_follow: assert property (wr_done
        && paddr == {IDX_DITHER, 2'b00} |-> ##2 {dither_rounding_select,
        dither_amplitude_select, dither_enable} == $past(pwdata[2:0], 2))
        else $error("dither controls");
    chk_ila_zero: assert property (ila_control_bits == 2'h0)
        else $error("control bits not zero");
    chk_reset_state: assert property ($rose(presetn) |-> dither_enable
        && !dither_amplitude_select && !marker_enable) else $error("reset");
    // Sample and marker both take five cycles from pin to output
    chk_marker_wide: assert property (pipe_full
        && marker_enable && $past(marker_enable)
        && !narrow_mode && !$past(narrow_mode) |-> sample_out ==
        {$past(sample_in[11:1], 5), $past(timestamp_in, 5)})
        else $error("wide");
    chk_marker_narrow: assert property (pipe_full
        && marker_enable && narrow_mode
        && $past(marker_enable) && $past(narrow_mode) |-> sample_out[11:4]
        == {$past(sample_in[11:5], 5), $past(timestamp_in, 5)})
        else $error("narrow");
    chk_marker_off: assert property (pipe_full
        && !marker_enable && !$past(marker_enable)
        |-> sample_out == $past(sample_in, 5))
        else $error("sample altered with marker off");

    cover property (wr_done && paddr == {IDX_DITHER, 2'b00});
    cover property (marker_enable && narrow_mode && $past(narrow_mode));
    cover property (pslverr);
endmodule

bind tdm_regs tdm_regs_props chk (.*);

// >>> tb/trim_dither_marker_regs_test.sv
`timescale 1ns/1ps
module trim_dither_marker_regs_test;
    import tdm_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              fuse_valid, timestamp_in, narrow_mode, marker_enable;
    logic              dither_enable, dither_amplitude_select;
    logic              dither_rounding_select;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, r;
    logic [7:0]        fuse_gain_a, fuse_gain_b, fuse_term_a, fuse_term_b;
    logic [7:0]        fuse_dither, gain_a_trim, gain_b_trim;
    logic [7:0]        term_a_trim, term_b_trim;
    logic [3:0]        fuse_ref, reference_trim;
    logic [1:0]        ila_control_bits;
    logic [11:0]       sample_in, sample_out;
    logic [32:0]       e;
    logic [32:0]       exp_q [$];
    logic [8:0]        idx [8] = '{IDX_GAIN_A, IDX_GAIN_B, IDX_REF,
        IDX_TERM_A, IDX_TERM_B, IDX_DITHER, IDX_MARKER, IDX_FUSE_ST};
    logic [7:0]        msk [8] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff,
        8'h07, 8'h01, 8'h00};
    logic [7:0]        mdl [8];
    int                failures = 0, cmp_count = 0, cycles = 0, i, j;
    integer            seed = 26836;

    tdm_regs #(.LATENCY(4)) DUT (.*);

    // Free running clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task cmp_val(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        cmp_val(got, exp);
    endtask
    // Setup then access, held until ready is seen high
    task apb(input logic w, input logic [10:0] a, input logic [31:0] d,
             input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input int n, input logic [31:0] d);
        apb(1'b1, {idx[n], 2'b00}, d, 33'h0);
        mdl[n] = d[7:0] & msk[n];
    endtask
    task rd(input int n);
        apb(1'b0, {idx[n], 2'b00}, 32'h0, {25'h0, mdl[n]});
    endtask
    task print_verdict();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            cmp_bus({pslverr, pwrite ? 32'h0 : prdata}, e);
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, fuse_valid, paddr, pwdata} = '0;
        {timestamp_in, narrow_mode, sample_in, fuse_ref} = '0;
        {fuse_gain_a, fuse_gain_b, fuse_term_a, fuse_term_b} = '0;
        fuse_dither = '0;
        mdl = '{5: 8'h01, default: 8'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) rd(i);
        // Factory values arrive, then read back
        r = $random(seed);
        {fuse_gain_a, fuse_gain_b, fuse_term_a, fuse_term_b} <= r;
        r = $random(seed);
        {fuse_ref, fuse_dither} <= r[11:0];
        fuse_valid <= 1'b1;
        repeat (5) @(posedge pclk);
        mdl = '{fuse_gain_a, fuse_gain_b, {4'h0, fuse_ref}, fuse_term_a,
            fuse_term_b, fuse_dither & 8'h07, 8'h00, 8'h01};
        for (i = 0; i < 8; i++) rd(i);
        // Overwrite all, every dither code once
        for (j = 0; j < 8; j++) begin
            for (i = 0; i < 7; i++) begin
                r = $random(seed);
                if (i == 5) r[2:0] = j[2:0];
                wr(i, r);
            end
            for (i = 0; i < 8; i++) rd(i);
            cmp_val({gain_a_trim, gain_b_trim, term_a_trim, term_b_trim},
                {mdl[0], mdl[1], mdl[3], mdl[4]});
            cmp_val({reference_trim, dither_rounding_select,
                dither_amplitude_select, dither_enable, marker_enable},
                {mdl[2][3:0], mdl[5][2:0], mdl[6][0]});
        end
        // Unmapped and misaligned are refused
        apb(1'b0, 11'h100, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 11'h1e9, 32'h5a, {1'b1, 32'h0});
        rd(0);
        // Marker on, then off, over both sample widths
        for (j = 0; j < 2; j++) begin
            wr(6, {31'h0, ~j[0]});
            repeat (2) @(posedge pclk);
            cmp_val({32'h0, marker_enable}, {32'h0, ~j[0]});
            for (i = 0; i < 40; i++) begin
                @(posedge pclk);
                r = $random(seed);
                sample_in <= r[11:0];
                timestamp_in <= r[12];
                if (i % 10 == 0) narrow_mode <= ~narrow_mode;
            end
        end
        // Second reset mid-run
        fuse_valid <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mdl = '{5: 8'h01, default: 8'h00};
        rd(5);
        rd(0);
        print_verdict();
    end
endmodule
